// ### pkg/sfb_consts.svh
// sfb_consts.svh: offsets, field positions and reset values of the
// special function register bank
// assumes: included by the register bank design file by bare name
`ifndef SFB_CONSTS_SVH
`define SFB_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SFB_OFS_ENABLE_ONE 4'h0
`define SFB_OFS_ENABLE_TWO 4'h1
`define SFB_OFS_FLAG_ONE 4'h2
`define SFB_OFS_FLAG_TWO 4'h3

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SFB_BIT_WDOG 0
`define SFB_BIT_OSC 1
`define SFB_BIT_PIN 4
`define SFB_BIT_FLASH 5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SFB_RST_ENABLE 1'b0
`define SFB_RST_PIN_FLAG 1'b0
`define SFB_RST_OSC_FLAG 1'b1
`define SFB_RST_WDOG_FLAG 1'b0

`endif

// ### pkg/sfb_pkg.sv
// sfb_pkg.sv: types shared by the special function register bank
// assumes: compiled before the design files
package sfb_pkg;
  typedef logic [7:0] sfb_byte_t;
  typedef logic [3:0] sfb_addr_t;
  // clear phase of the bank: power-on, power-up clear, running
  typedef enum logic [2:0] {
    SFB_POR = 3'b001,
    SFB_CLR = 3'b010,
    SFB_RUN = 3'b100
  } sfb_phase_e;
endpackage

// ### rtl/sfb_flag_bit.sv
// sfb_flag_bit.sv: one sticky flag bit with set, software write, clear
// assumes: one clock, set and clear are one-cycle or level requests
`timescale 1ns/100ps
module sfb_flag_bit (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control
  input wire logic init_load,
  input wire logic init_value,
  input wire logic hw_set,
  input wire logic hw_clear,
  input wire logic sw_write,
  input wire logic sw_value,
  // state
  output logic flag_reg
);
  logic flag_next;
  // hardware set wins over any software write or clear in the same cycle
  assign flag_next = hw_set ? 1'b1 :
                     init_load ? init_value :
                     hw_clear ? 1'b0 :
                     sw_write ? sw_value : flag_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end
endmodule

// ### rtl/sfb_special_function_register.sv
// sfb_special_function_register.sv: bank of byte-wide enable and flag
// registers at the lowest addresses, with request outputs per source
// assumes: cpu strobes are one cycle; event inputs are synchronous;
// reset_n is the power-on reset, power_up_clear a synchronous pulse/level
// the cpu's global enable is not an input: these sources are gated
// only by their own enable bit, which software must clear to mask them
//
// Operation
// - enable and flag bytes sit at lowest addresses 0h and 02h
// - unassigned bits and bytes 01h, 03h have no storage, read zero
// - enable byte: flash bit5, pin bit4, oscillator bit1, watchdog bit0
// - watchdog enable gates request only in interval timer mode
// - flag byte: pin bit4, oscillator bit1, watchdog bit0, all rw
// - watchdog flag set on overflow in watchdog mode or bad key
// - watchdog flag cleared by power-on or reset from the pin
// - oscillator fault flag set while monitor reports a fault
// - pin interrupt flag set on pin non-maskable event
// - power-up clear zeroes enables and pin flag, sets oscillator flag
// - watchdog flag reset only by power-on or pin reset, kept over power-up clear
// - only individual enables block these requests, not global enable
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`include "sfb_consts.svh"
module sfb_special_function_register (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic power_up_clear,
  // register port
  input wire sfb_pkg::sfb_addr_t bus_addr,
  input wire sfb_pkg::sfb_byte_t bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output sfb_pkg::sfb_byte_t bus_rdata,
  // event sources
  input wire logic wdog_interval_mode,
  input wire logic wdog_overflow,
  input wire logic wdog_key_violation,
  input wire logic wdog_interval_event,
  input wire logic pin_reset_event,
  input wire logic osc_fault_event,
  input wire logic pin_nmi_event,
  input wire logic flash_violation_event,
  // requests toward the cpu
  output logic wdog_irq_req,
  output logic osc_fault_req,
  output logic pin_irq_req,
  output logic flash_violation_req,
  output logic wdog_flag_out
);
  import sfb_pkg::*;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input sfb_addr_t a, input sfb_addr_t ofs);
    hit = (a == ofs);
  endfunction

  wire logic wr_enable = bus_write && hit(bus_addr, `SFB_OFS_ENABLE_ONE);
  wire logic wr_flag = bus_write && hit(bus_addr, `SFB_OFS_FLAG_ONE);

  // ----------------------------------------------------------------------
  // clear phase after power-on
  // ----------------------------------------------------------------------
  // power-on itself is a power-up clear, so the first cycle after
  // release loads the clear values; async reset only takes constants
  sfb_phase_e phase_reg;
  sfb_phase_e phase_next;
  always_comb begin
    phase_next = SFB_RUN;
    unique case (phase_reg)
      SFB_POR: phase_next = SFB_CLR;
      SFB_CLR: phase_next = power_up_clear ? SFB_CLR : SFB_RUN;
      SFB_RUN: phase_next = power_up_clear ? SFB_CLR : SFB_RUN;
      default: phase_next = SFB_CLR;
    endcase
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= SFB_POR;
    end else begin
      phase_reg <= phase_next;
    end
  end
  // the clear phase outlasts a pulse by one cycle, so a write racing the
  // end of the clear is still overridden
  wire logic clr_active = (phase_reg != SFB_RUN) || power_up_clear;

  // ----------------------------------------------------------------------
  // enable byte: only four bits exist
  // ----------------------------------------------------------------------
  // bits 7:6 and 3:2 have no flops; writes to them are simply dropped
  logic [3:0] enable_reg; // wdog, osc, pin, flash
  logic [3:0] enable_next;
  wire logic [3:0] enable_wval = {bus_wdata[`SFB_BIT_FLASH],
    bus_wdata[`SFB_BIT_PIN], bus_wdata[`SFB_BIT_OSC],
    bus_wdata[`SFB_BIT_WDOG]};
  assign enable_next = clr_active ? {4{`SFB_RST_ENABLE}} :
                       wr_enable ? enable_wval : enable_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      enable_reg <= 4'h0;
    end else begin
      enable_reg <= enable_next;
    end
  end

  // ----------------------------------------------------------------------
  // flag bits
  // ----------------------------------------------------------------------
  logic [2:0] flag_q; // wdog, osc, pin
  wire logic [2:0] flag_set = {pin_nmi_event, osc_fault_event,
    wdog_overflow && !wdog_interval_mode || wdog_key_violation ||
    wdog_interval_event && wdog_interval_mode};
  wire logic [2:0] flag_init = {`SFB_RST_PIN_FLAG, `SFB_RST_OSC_FLAG,
    `SFB_RST_WDOG_FLAG};
  // watchdog flag is not touched by power-up clear
  wire logic [2:0] flag_load = {clr_active, clr_active,
    phase_reg == SFB_POR};
  // a set in the same cycle as a pin reset wins; the event is newer
  wire logic [2:0] flag_clr = {2'b00, pin_reset_event};
  wire logic [2:0] flag_wval = {bus_wdata[`SFB_BIT_PIN],
    bus_wdata[`SFB_BIT_OSC], bus_wdata[`SFB_BIT_WDOG]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_flag
      sfb_flag_bit u_flag (
        .clock(clock),
        .reset_n(reset_n),
        .init_load(flag_load[gi]),
        .init_value(flag_init[gi]),
        .hw_set(flag_set[gi]),
        .hw_clear(flag_clr[gi]),
        .sw_write(wr_flag),
        .sw_value(flag_wval[gi]),
        .flag_reg(flag_q[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  // absent bits and bytes read zero, unmapped offsets too
  wire sfb_byte_t enable_byte = {2'b00, enable_reg[3], enable_reg[2],
    2'b00, enable_reg[1], enable_reg[0]};
  wire sfb_byte_t flag_byte = {3'b000, flag_q[2], 2'b00, flag_q[1],
    flag_q[0]};
  wire sfb_byte_t rdata_sel =
    hit(bus_addr, `SFB_OFS_ENABLE_ONE) ? enable_byte :
    hit(bus_addr, `SFB_OFS_FLAG_ONE) ? flag_byte : 8'h00;
  // the registered read costs a cycle but keeps bus_rdata on a flop
  sfb_byte_t rdata_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= bus_read ? rdata_sel : 8'h00;
    end
  end
  assign bus_rdata = rdata_reg;

  // ----------------------------------------------------------------------
  // requests
  // ----------------------------------------------------------------------
  // no global enable input: these sources are blocked by their own bit
  wire logic [3:0] req_next = {flash_violation_event && enable_reg[3],
    flag_q[2] && enable_reg[2], flag_q[1] && enable_reg[1],
    flag_q[0] && enable_reg[0] && wdog_interval_mode};
  // the flag copy lets restart logic tell a watchdog restart apart
  logic [3:0] req_reg;
  logic wflag_reg;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      req_reg <= 4'h0;
      wflag_reg <= 1'b0;
    end else begin
      req_reg <= req_next;
      wflag_reg <= flag_q[0];
    end
  end
  assign wdog_irq_req = req_reg[0];
  assign osc_fault_req = req_reg[1];
  assign pin_irq_req = req_reg[2];
  assign flash_violation_req = req_reg[3];
  assign wdog_flag_out = wflag_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence s_clear_pulse;
    power_up_clear;
  endsequence
  sequence s_clear_result;
    ##1 (enable_reg == 4'h0) && !flag_q[2] && flag_q[1];
  endsequence

  a_clear_bits: assert property (
    @(posedge clock) disable iff (!reset_n)
    s_clear_pulse |-> s_clear_result)
    else $error("power-up clear left enables or flags wrong");

  a_clear_keeps_wdog: assert property (
    @(posedge clock) disable iff (!reset_n)
    power_up_clear && phase_reg == SFB_RUN && !flag_set[0]
    && !pin_reset_event && !wr_flag |=> flag_q[0] == $past(flag_q[0]))
    else $error("power-up clear changed the watchdog flag");

  a_wdog_set: assert property (
    @(posedge clock) disable iff (!reset_n)
    wdog_key_violation |=> flag_q[0])
    else $error("watchdog flag not set on key violation");

  a_wdog_pin_clr: assert property (
    @(posedge clock) disable iff (!reset_n)
    pin_reset_event && !flag_set[0] |=> !flag_q[0])
    else $error("watchdog flag not cleared by pin reset");

  a_osc_set: assert property (
    @(posedge clock) disable iff (!reset_n)
    osc_fault_event |=> flag_q[1])
    else $error("oscillator fault flag not set");

  a_pin_set: assert property (
    @(posedge clock) disable iff (!reset_n)
    pin_nmi_event |=> flag_q[2])
    else $error("pin interrupt flag not set");

  a_enable_write: assert property (
    @(posedge clock) disable iff (!reset_n)
    wr_enable && !clr_active |=> enable_byte == ($past(bus_wdata) & 8'h33))
    else $error("enable byte write not stored");

  a_read_data: assert property (
    @(posedge clock) disable iff (!reset_n)
    bus_read && (hit(bus_addr, `SFB_OFS_ENABLE_TWO)
    || hit(bus_addr, `SFB_OFS_FLAG_TWO)) |=> bus_rdata == 8'h00)
    else $error("absent register read non-zero");

  a_wdog_gate: assert property (
    @(posedge clock) disable iff (!reset_n)
    !wdog_interval_mode |=> !wdog_irq_req)
    else $error("watchdog request in reset mode");

  a_osc_request: assert property (
    @(posedge clock) disable iff (!reset_n)
    flag_q[1] && enable_reg[1] |=> osc_fault_req)
    else $error("oscillator request not raised");

  a_pin_request: assert property (
    @(posedge clock) disable iff (!reset_n)
    flag_q[2] && enable_reg[2] |=> pin_irq_req)
    else $error("pin interrupt request not raised");

  a_wdog_request: assert property (
    @(posedge clock) disable iff (!reset_n)
    flag_q[0] && enable_reg[0] && wdog_interval_mode |=> wdog_irq_req)
    else $error("watchdog request not raised in interval mode");

  a_requests_drop: assert property (
    @(posedge clock) disable iff (!reset_n)
    flag_q == 3'b000 |=> !wdog_irq_req && !osc_fault_req && !pin_irq_req)
    else $error("request stayed up after its flag cleared");

  // flash violation has no flag here: the request follows the event
  a_flash_request: assert property (
    @(posedge clock) disable iff (!reset_n)
    flash_violation_event && enable_reg[3] |=> flash_violation_req)
    else $error("flash violation request not raised");

  a_flash_blocked: assert property (
    @(posedge clock) disable iff (!reset_n)
    !enable_reg[3] |=> !flash_violation_req)
    else $error("flash violation request without its enable");

  // ----------------------------------------------------------------------
  // clear, load and hold checks
  // ----------------------------------------------------------------------
  sequence s_clear_idle;
    !power_up_clear;
  endsequence

  // the clear holds one cycle past the pulse, then the bank runs again
  a_clear_length: assert property (
    @(posedge clock) disable iff (!reset_n)
    s_clear_pulse ##1 s_clear_idle |=> phase_reg == SFB_RUN
    && enable_reg == 4'h0)
    else $error("power-up clear phase has the wrong length");

  // the release edge itself is still in reset, so only judge the load
  // once reset_n is sampled high
  a_por_load: assert property (
    @(posedge clock) disable iff (!reset_n)
    reset_n && phase_reg == SFB_POR && flag_set == 3'b000
    |=> !flag_q[0] && flag_q[1] && !flag_q[2])
    else $error("power-on load of the flags wrong");

  a_wflag_copy: assert property (
    @(posedge clock) disable iff (!reset_n)
    1'b1 |=> wdog_flag_out == $past(flag_q[0]))
    else $error("watchdog flag output does not follow the flag");

  // nothing but a write, a clear or an event may move a stored bit
  a_enable_kept: assert property (
    @(posedge clock) disable iff (!reset_n)
    !wr_enable && !clr_active |=> enable_reg == $past(enable_reg))
    else $error("enable bits moved without a write");

  a_flag_kept: assert property (
    @(posedge clock) disable iff (!reset_n)
    !wr_flag && !clr_active && flag_set == 3'b000 && !pin_reset_event
    |=> flag_q == $past(flag_q))
    else $error("flag bits moved without a cause");

  a_flag_write: assert property (
    @(posedge clock) disable iff (!reset_n)
    wr_flag && !clr_active && flag_set == 3'b000 && !pin_reset_event
    |=> flag_byte == ($past(bus_wdata) & 8'h13))
    else $error("flag byte write not stored");

  a_absent_write: assert property (
    @(posedge clock) disable iff (!reset_n)
    bus_write && !wr_enable && !wr_flag && !clr_active
    && flag_set == 3'b000 && !pin_reset_event
    |=> {enable_reg, flag_q} == $past({enable_reg, flag_q}))
    else $error("write to an absent register changed stored bits");

  // read data stand for exactly one cycle and are zero otherwise
  a_enable_read: assert property (
    @(posedge clock) disable iff (!reset_n)
    bus_read && hit(bus_addr, `SFB_OFS_ENABLE_ONE)
    |=> bus_rdata == $past(enable_byte))
    else $error("enable byte read back wrong");

  a_flag_read: assert property (
    @(posedge clock) disable iff (!reset_n)
    bus_read && hit(bus_addr, `SFB_OFS_FLAG_ONE)
    |=> bus_rdata == $past(flag_byte))
    else $error("flag byte read back wrong");

  a_rdata_idle: assert property (
    @(posedge clock) disable iff (!reset_n)
    !bus_read |=> bus_rdata == 8'h00)
    else $error("read data present without a read");
endmodule

// ### sim/sfb_event_model.sv
// sfb_event_model.sv: stand-in for the watchdog, oscillator monitor, pin
// logic and flash controller that raise events into the bank
// assumes: one clock; the bench names one source and holds ev_go high
`timescale 1ns/100ps
module sfb_event_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // command from the bench
  input wire logic ev_go,
  input wire logic [2:0] ev_sel,
  // event lines, one bit per source
  output logic [6:0] ev_out
);
  // -------------------------------------------------------------------
  // event drive
  // -------------------------------------------------------------------
  // levels, not pulses: a real source holds its condition for a while
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ev_out <= 7'h00;
    end else begin
      ev_out <= ev_go ? (7'h01 << ev_sel) : 7'h00;
    end
  end
endmodule

// ### sim/system_irq_enable_flag_bank_tb.sv
// system_irq_enable_flag_bank_tb.sv: register and event tests of the bank
// assumes: sfb_pkg and the design files are compiled first
`timescale 1ns/100ps
module system_irq_enable_flag_bank_tb;
  import sfb_pkg::*;
  logic clock, reset_n, power_up_clear, bus_write, bus_read;
  logic wdog_interval_mode, ev_go;
  logic wreq, oreq, preq, freq, wflag;
  logic [2:0] ev_sel;
  logic [6:0] ev;
  sfb_addr_t bus_addr;
  sfb_byte_t bus_wdata, bus_rdata;
  int fails, n_tests;

  sfb_special_function_register sfb_special_function_register_i (
    .clock(clock), .reset_n(reset_n), .power_up_clear(power_up_clear),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
    .bus_read(bus_read), .bus_rdata(bus_rdata),
    .wdog_interval_mode(wdog_interval_mode), .wdog_overflow(ev[0]),
    .wdog_key_violation(ev[1]), .wdog_interval_event(ev[2]),
    .pin_reset_event(ev[3]), .osc_fault_event(ev[4]),
    .pin_nmi_event(ev[5]), .flash_violation_event(ev[6]),
    .wdog_irq_req(wreq), .osc_fault_req(oreq), .pin_irq_req(preq),
    .flash_violation_req(freq), .wdog_flag_out(wflag));

  sfb_event_model sfb_event_model_i (
    .clock(clock), .reset_n(reset_n), .ev_go(ev_go), .ev_sel(ev_sel),
    .ev_out(ev));

  // -------------------------------------------------------------------
  // access tasks
  // -------------------------------------------------------------------
  task automatic chk(input sfb_byte_t got, input sfb_byte_t exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input sfb_addr_t a, input sfb_byte_t d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clock);
    bus_write <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input sfb_addr_t a, input sfb_byte_t exp);
    @(posedge clock);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clock);
    bus_read <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask

  // request byte: flag copy, watchdog, oscillator, pin, flash
  task automatic reqs(input sfb_byte_t exp);
    repeat (2) @(posedge clock);
    #1 chk({3'h0, wflag, wreq, oreq, preq, freq}, exp);
  endtask

  task automatic ev_hold(input logic [2:0] sel);
    @(posedge clock);
    ev_go <= 1'b1;
    ev_sel <= sel;
    repeat (3) @(posedge clock);
    ev_go <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // -------------------------------------------------------------------
  // clock, watchdog
  // -------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // the tests need some 130 cycles; 4000 leaves a wide margin
  initial begin
    #20000;
    fails++;
    tally_and_finish;
  end

  // -------------------------------------------------------------------
  // tests
  // -------------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    power_up_clear = 1'b0;
    bus_write = 1'b0;
    bus_read = 1'b0;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    wdog_interval_mode = 1'b0;
    ev_go = 1'b0;
    ev_sel = 3'h0;
    fails = 0;
    n_tests = 0;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h02);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h33);
    // unassigned bytes and an unmapped address keep nothing
    wr(4'h1, 8'hff);
    wr(4'h3, 8'hff);
    wr(4'h9, 8'hff);
    rd(4'h1, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'h9, 8'h00);
    rd(4'h0, 8'h33);
    wr(4'h2, 8'hff);
    rd(4'h2, 8'h13);
    reqs(8'h16);
    @(posedge clock) wdog_interval_mode <= 1'b1;
    reqs(8'h1e);
    wr(4'h2, 8'h00);
    rd(4'h2, 8'h00);
    reqs(8'h00);
    @(posedge clock) wdog_interval_mode <= 1'b0;
    ev_hold(3'd4);
    rd(4'h2, 8'h02);
    ev_hold(3'd5);
    rd(4'h2, 8'h12);
    ev_hold(3'd0);
    rd(4'h2, 8'h13);
    ev_hold(3'd3);
    rd(4'h2, 8'h12);
    ev_hold(3'd1);
    rd(4'h2, 8'h13);
    // interval mode: overflow no longer sets the flag, the interval does
    wr(4'h2, 8'h12);
    @(posedge clock) wdog_interval_mode <= 1'b1;
    ev_hold(3'd0);
    rd(4'h2, 8'h12);
    ev_hold(3'd2);
    rd(4'h2, 8'h13);
    @(posedge clock) wdog_interval_mode <= 1'b0;
    @(posedge clock);
    ev_go <= 1'b1;
    ev_sel <= 3'd6;
    reqs(8'h17);
    @(posedge clock) ev_go <= 1'b0;
    @(posedge clock) power_up_clear <= 1'b1;
    @(posedge clock) power_up_clear <= 1'b0;
    repeat (3) @(posedge clock);
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h03);
    reqs(8'h10);
    @(posedge clock) reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(4'h2, 8'h02);
    tally_and_finish;
  end
endmodule
